// File: serial_port_pkg.sv
// Constants shared by the serial port and its helper modules.
// Assumes an 8-bit CPU register port and a 200 MHz system clock.
package serial_port_pkg;
	localparam logic [7:0] ADDR_CONTROL = 8'h0A;
	localparam logic [7:0] ADDR_STATUS = 8'h0B;
	localparam logic [7:0] ADDR_DATA = 8'h0C;
	localparam int CTL_IRQ_EN_BIT = 7;
	localparam int CTL_ENABLE_BIT = 6;
	localparam int CTL_ORDER_BIT = 5;
	localparam int CTL_MASTER_BIT = 4;
	localparam int CTL_RATE_BIT = 0;
	localparam int STS_DONE_BIT = 7;
	localparam int STS_COLL_BIT = 6;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RW_MASK = 8'hF1;
	localparam logic [3:0] HALF_FAST = 4'h0;
	localparam logic [3:0] HALF_SLOW = 4'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOW = 2'b01,
		ST_HIGH = 2'b10
	} master_state_t;
endpackage : serial_port_pkg

// File: fifo_if.sv
// Valid/ready carrier between the port and its receive FIFO.
// Assumes both ends run on the system clock.
interface fifo_if #(parameter int W = 8) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : fifo_if

// File: byte_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes a synchronous active-low reset.
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	fifo_if.sink wr,
	fifo_if.source rd
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_reg;
	logic [AW:0] rp_reg;
	wire full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
	wire empty = (wp_reg == rp_reg);
	wire push = wr.valid && !full;
	wire pop = rd.ready && !empty;
	assign wr.ready = !full;
	assign rd.valid = !empty;
	assign rd.data = mem[rp_reg[AW-1:0]];
	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem[wp_reg[AW-1:0]] <= wr.data;
		end
	end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			wp_reg <= wp_reg + (AW + 1)'(push);
			rp_reg <= rp_reg + (AW + 1)'(pop);
		end
	end
endmodule : byte_fifo

// File: serial_peripheral_port.sv
// Serial peripheral port: control, status and shift-data registers, master clock generator.
// Assumes synchronous pins and a CPU register port with one-cycle read/write strobes.
// What this block does
// - Enable connects clock, data-out, data-in pins
// - Clearing enable resets state, releases pins
// - Master data write starts clock generator
// - Master rate: divide 16 or 2
// - Serial clock drives bit counter, shifter
// - Master drives clock pin; slave receives
// - Slave never generates clock on write
// - Order bit picks LSB or MSB first
// - Eighth rising clock edge sets done flag
// - Done flag with enable raises interrupt
// - Interrupt held while enable and flag set
// - Status read then data access clears done
// - Done set blocks data access, shifting
// - Access during shift sets collision, ignored
// - Collision never raises interrupt
// - Collision clears likewise, resets if shifting
// - Status read-only, others read-write
// - Unused bits read as zero
// - Data register survives reset
// - Stop freezes master transfer, then resumes
// - Slave shifts in stop, interrupt early
// - Wait mode leaves port running
// - Eight master pulses, clock idles high
// - Output data changes on falling edge, or on any cycle while master idle
module serial_peripheral_port
	import serial_port_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic stop_mode_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic transfer_interrupt_out,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe_out,
	output logic serial_out_pin_out,
	output logic serial_out_oe_out,
	input wire logic serial_in_pin_in,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	input wire logic rx_ready_in,
	output logic rx_overflow_out
);
	import serial_port_pkg::*;

	fifo_if #(.W(FIFO_WIDTH)) rx_wr ();
	fifo_if #(.W(FIFO_WIDTH)) rx_rd ();

	logic [7:0] control_reg;
	logic done_reg;
	logic coll_reg;
	logic armed_reg;
	logic [7:0] shift_reg;
	logic [2:0] count_reg;
	logic busy_reg;
	logic done_pend_reg;
	logic irq_early_reg;
	master_state_t mstate_reg;
	master_state_t mstate_next;
	logic [3:0] div_reg;
	logic sck_prev_reg;
	logic sdo_reg;
	logic push_reg;
	logic [7:0] push_data_reg;
	logic overflow_reg;
	logic [7:0] rdata_reg;
	logic irq_reg;
	logic sck_o_reg;
	logic sck_oe_reg;
	logic sdo_oe_reg;

	wire enabled = control_reg[CTL_ENABLE_BIT];
	wire master = control_reg[CTL_MASTER_BIT];
	wire lsb_first = control_reg[CTL_ORDER_BIT];
	wire irq_en = control_reg[CTL_IRQ_EN_BIT];
	wire slow_rate = control_reg[CTL_RATE_BIT];
	wire sel_ctl = (addr_in == ADDR_CONTROL);
	wire sel_sts = (addr_in == ADDR_STATUS);
	wire sel_dat = (addr_in == ADDR_DATA);
	wire data_access = sel_dat && (wr_in || rd_in);
	wire status_read = sel_sts && rd_in;
	// Clear sequence: status read seen with done set, then a data access
	wire clear_seq = data_access && armed_reg;
	// Data access blocked while done pending clear or while shifting
	wire access_ok = data_access && !done_reg && !busy_reg;
	wire collide = data_access && busy_reg && !(done_reg && !armed_reg);
	wire data_write_ok = access_ok && wr_in;
	wire [3:0] half_count = slow_rate ? HALF_SLOW : HALF_FAST;
	wire div_done = (div_reg == half_count);
	wire clk_run = !stop_mode_in;

	// Serial clock edges: internal in master mode, pin in slave mode
	wire m_rise = (mstate_reg == ST_LOW) && div_done && clk_run;
	wire m_fall = (mstate_reg == ST_HIGH) && div_done && clk_run;
	wire s_rise = !master && sck_in && !sck_prev_reg;
	wire s_fall = !master && !sck_in && sck_prev_reg;
	wire ser_rise = enabled && !done_reg && (master ? m_rise : s_rise);
	wire ser_fall = enabled && (master ? (m_fall || mstate_reg == ST_IDLE) : s_fall);
	wire last_bit = (count_reg == BIT_LAST);
	wire in_bit = serial_in_pin_in;
	wire [7:0] shifted = lsb_first ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};
	wire out_bit = lsb_first ? shift_reg[0] : shift_reg[7];
	wire start_master = enabled && master && data_write_ok;

	always_comb begin
		mstate_next = mstate_reg;
		case (mstate_reg)
			ST_IDLE: begin
				if (start_master) begin
					mstate_next = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (m_fall) begin
					mstate_next = ST_LOW;
				end
			end
			ST_LOW: begin
				if (m_rise) begin
					mstate_next = last_bit ? ST_IDLE : ST_HIGH;
				end
			end
			default: begin
				mstate_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !enabled || !master) begin
			mstate_reg <= ST_IDLE;
			div_reg <= '0;
		end else begin
			mstate_reg <= mstate_next;
			if (mstate_reg == ST_IDLE || div_done) begin
				div_reg <= '0;
			end else if (clk_run) begin
				div_reg <= div_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			control_reg <= CONTROL_RESET;
		end else if (wr_in && sel_ctl) begin
			control_reg <= wdata_in & CONTROL_RW_MASK;
		end
	end

	// Shift register has no reset; it keeps its byte as plain storage
	always_ff @(posedge clk_sys_in) begin
		if (data_write_ok) begin
			shift_reg <= wdata_in;
		end else if (ser_rise) begin
			shift_reg <= shifted;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || !enabled) begin
			count_reg <= '0;
			busy_reg <= 1'b0;
			done_pend_reg <= 1'b0;
			irq_early_reg <= 1'b0;
		end else begin
			if (ser_rise) begin
				count_reg <= count_reg + 3'h1;
				busy_reg <= !last_bit;
			end else if (start_master || (s_fall && !done_reg)) begin
				busy_reg <= 1'b1;
			end
			// Slave byte end in stop: interrupt now, flag when clock returns
			if (ser_rise && last_bit && stop_mode_in) begin
				done_pend_reg <= 1'b1;
				irq_early_reg <= 1'b1;
			end else if (!stop_mode_in) begin
				done_pend_reg <= 1'b0;
				irq_early_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			done_reg <= 1'b0;
			coll_reg <= 1'b0;
			armed_reg <= 1'b0;
		end else begin
			// Setting wins over the clear sequence
			if ((ser_rise && last_bit && !stop_mode_in) || (done_pend_reg && !stop_mode_in)) begin
				done_reg <= 1'b1;
			end else if (clear_seq) begin
				done_reg <= 1'b0;
			end
			if (collide) begin
				coll_reg <= 1'b1;
			end else if (clear_seq) begin
				coll_reg <= 1'b0;
			end
			if (status_read && done_reg) begin
				armed_reg <= 1'b1;
			end else if (data_access) begin
				armed_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			sck_prev_reg <= 1'b1;
			sdo_reg <= 1'b1;
			sck_o_reg <= 1'b1;
			sck_oe_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
			irq_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			sck_prev_reg <= sck_in;
			if (ser_fall) begin
				sdo_reg <= out_bit;
			end
			sck_o_reg <= (mstate_next != ST_LOW);
			sck_oe_reg <= enabled && master;
			sdo_oe_reg <= enabled;
			irq_reg <= irq_en && (done_reg || irq_early_reg);
			rdata_reg <= sel_ctl ? control_reg :
				sel_sts ? {done_reg, coll_reg, 6'h00} :
				sel_dat ? shift_reg : 8'h00;
		end
	end

	// Received bytes copied into the FIFO at byte end
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			push_reg <= 1'b0;
			push_data_reg <= 8'h00;
			overflow_reg <= 1'b0;
		end else begin
			if (ser_rise && last_bit) begin
				push_reg <= 1'b1;
				push_data_reg <= shifted;
				overflow_reg <= push_reg && !rx_wr.ready;
			end else if (rx_wr.ready) begin
				push_reg <= 1'b0;
			end
		end
	end

	assign rx_wr.valid = push_reg;
	assign rx_wr.data = push_data_reg;
	assign rx_rd.ready = rx_ready_in || !rx_valid_out;

	byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.wr(rx_wr.sink),
		.rd(rx_rd.source)
	);

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rx_valid_out <= 1'b0;
			rx_data_out <= 8'h00;
		end else if (!rx_valid_out || rx_ready_in) begin
			rx_valid_out <= rx_rd.valid;
			rx_data_out <= rx_rd.data;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rx_overflow_out <= 1'b0;
		end else begin
			rx_overflow_out <= overflow_reg;
		end
	end

	assign rdata_out = rdata_reg;
	assign transfer_interrupt_out = irq_reg;
	assign sck_out = sck_o_reg;
	assign sck_oe_out = sck_oe_reg;
	assign serial_out_pin_out = sdo_reg;
	assign serial_out_oe_out = sdo_oe_reg;
endmodule : serial_peripheral_port

// File: serial_peripheral_port_sva.sv
// Port-level checker for the serial port.
// Assumes the control register changes only by CPU writes.
module serial_peripheral_port_sva
	import serial_port_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic stop_mode_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic transfer_interrupt_out,
	input wire logic sck_out,
	input wire logic sck_oe_out,
	input wire logic serial_out_oe_out
);
	logic [7:0] ctl_reg;
	logic [3:0] falls_reg;
	logic en;
	logic mst;
	logic ie;
	assign en = ctl_reg[CTL_ENABLE_BIT];
	assign mst = ctl_reg[CTL_MASTER_BIT];
	assign ie = ctl_reg[CTL_IRQ_EN_BIT];
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			ctl_reg <= CONTROL_RESET;
		else if (wr_in && addr_in == ADDR_CONTROL)
			ctl_reg <= wdata_in & CONTROL_RW_MASK;
	end
	// Clock falls since the last data write
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in || (wr_in && addr_in == ADDR_DATA))
			falls_reg <= 4'h0;
		else if ($fell(sck_out) && sck_oe_out)
			falls_reg <= falls_reg + 4'h1;
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	chk_pins_released: assert property (!en |=> !sck_oe_out && !serial_out_oe_out)
		else $error("pins not released");
	chk_master_drives: assert property (en && mst |=> sck_oe_out && serial_out_oe_out)
		else $error("master pins idle");
	chk_slave_input: assert property (en && !mst |=> !sck_oe_out)
		else $error("slave drives clock");
	chk_fast_half: assert property ($fell(sck_out) && sck_oe_out && !ctl_reg[0]
		&& !stop_mode_in |=> sck_out || stop_mode_in) else $error("fast half period");
	chk_slow_half: assert property ($fell(sck_out) && sck_oe_out && ctl_reg[0]
		|-> !sck_out [*8]) else $error("slow half period");
	chk_eight_pulses: assert property (falls_reg <= 4'h8)
		else $error("too many pulses");
	chk_irq_enable: assert property (transfer_interrupt_out |-> $past(ie))
		else $error("irq while disabled");
	chk_ctl_read: assert property (rd_in && addr_in == ADDR_CONTROL
		|=> rdata_out == $past(ctl_reg)) else $error("control readback");
	chk_status_zero: assert property (rd_in && addr_in == ADDR_STATUS
		|=> rdata_out[5:0] == 6'h00) else $error("status spare bits");
endmodule : serial_peripheral_port_sva
bind serial_peripheral_port serial_peripheral_port_sva chk_i (.clk_sys_in, .rst_n_in,
	.stop_mode_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .transfer_interrupt_out,
	.sck_out, .sck_oe_out, .serial_out_oe_out);

// File: spi_far_end.sv
// Far-side device: answers on the data line, clocks slave transfers.
// Assumes the bench resolves the clock pin level.
module spi_far_end (
	input wire logic clk_sys_in,
	input wire logic go_in,
	input wire logic [7:0] tx_in,
	input wire logic line_in,
	input wire logic dut_oe_in,
	input wire logic mosi_in,
	output logic sck_out,
	output logic miso_out,
	output logic [7:0] rx_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sh;
	initial begin
		sck_out = 1'b1;
		miso_out = 1'b0;
		sh = 8'h00;
		rx_out = 8'h00;
	end
	always @(negedge line_in) begin
		miso_out <= sh[7];
		sh <= {sh[6:0], ~sh[7]};
	end
	always @(posedge line_in) rx_out <= {rx_out[6:0], mosi_in};
	always @(posedge clk_sys_in) begin
		if (go_in) begin
			sh <= tx_in;
			if (!dut_oe_in) begin
				repeat (8) begin
					@(posedge clk_sys_in) sck_out <= 1'b0;
					repeat (4) @(posedge clk_sys_in);
					sck_out <= 1'b1;
					repeat (4) @(posedge clk_sys_in);
				end
			end
		end
	end
endmodule : spi_far_end

// File: serial_peripheral_port_tb.sv
// Self-checking bench for the serial port.
// Assumes the checker binds itself and the far end is spi_far_end.
module serial_peripheral_port_tb;
	import serial_port_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0, rst_n_in = 1'b0, stop_mode_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
	logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, far_tx = 8'h00, rdata_out, rx_data_out, far_rx;
	logic transfer_interrupt_out, sck_out, sck_oe_out, serial_out_pin_out, serial_out_oe_out;
	logic serial_in_pin_in, rx_valid_out, rx_overflow_out, far_sck, go = 1'b0, rx_ready_in = 1'b0;
	wire sck_line = sck_oe_out ? sck_out : far_sck;
	int n_mismatch = 0, checks_done = 0, cycles = 0;
	serial_peripheral_port dut (.clk_sys_in, .rst_n_in, .stop_mode_in, .addr_in, .wdata_in,
		.wr_in, .rd_in, .rdata_out, .transfer_interrupt_out, .sck_in(sck_line), .sck_out,
		.sck_oe_out, .serial_out_pin_out, .serial_out_oe_out, .serial_in_pin_in, .rx_valid_out,
		.rx_data_out, .rx_ready_in, .rx_overflow_out);
	spi_far_end far (.clk_sys_in, .go_in(go), .tx_in(far_tx), .line_in(sck_line),
		.dut_oe_in(sck_oe_out), .mosi_in(serial_out_pin_out), .sck_out(far_sck),
		.miso_out(serial_in_pin_in), .rx_out(far_rx));
	initial begin
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in) wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in) rd_in <= 1'b0;
		@(negedge clk_sys_in);
		chk(rdata_out, e);
	endtask : rd
	task automatic wait_irq();
		int i;
		for (i = 0; i < 400 && transfer_interrupt_out !== 1'b1; i++) @(negedge clk_sys_in);
		chk(transfer_interrupt_out, 1);
	endtask : wait_irq
	task automatic pulse_go(input logic [7:0] t);
		@(posedge clk_sys_in);
		far_tx <= t;
		go <= 1'b1;
		@(posedge clk_sys_in) go <= 1'b0;
	endtask : pulse_go
	task automatic s_regs();
		rd(ADDR_CONTROL, 8'h00);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL, 8'hFF);
		rd(ADDR_CONTROL, 8'hF1);
		wr(ADDR_STATUS, 8'hFF);
		rd(ADDR_STATUS, 8'h00);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_DATA, 8'h5A);
		@(posedge clk_sys_in) rst_n_in <= 1'b0;
		repeat (10) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rd(ADDR_DATA, 8'h5A);
	endtask : s_regs
	task automatic s_master();
		int i;
		wr(ADDR_CONTROL, 8'hD0);
		for (i = 0; i < 10; i++) begin
			pulse_go(8'hC0 + i[7:0]);
			wr(ADDR_DATA, 8'h30 + i[7:0]);
			wait_irq();
			chk(far_rx, 8'h30 + i[7:0]);
			rd(ADDR_STATUS, 8'h80);
			rd(ADDR_DATA, 8'hC0 + i[7:0]);
			repeat (2) @(negedge clk_sys_in);
			chk(transfer_interrupt_out, 0);
		end
		for (i = 0; i < 8; i++) begin
			@(negedge clk_sys_in);
			chk({rx_valid_out, rx_data_out}, {1'b1, 8'hC0 + i[7:0]});
			@(posedge clk_sys_in) rx_ready_in <= 1'b1;
			@(posedge clk_sys_in) rx_ready_in <= 1'b0;
			repeat (4) @(posedge clk_sys_in);
		end
		chk(rx_overflow_out, 0);
	endtask : s_master
	task automatic s_slow();
		logic [1:0] held;
		wr(ADDR_CONTROL, 8'hF1);
		pulse_go(8'h96);
		wr(ADDR_DATA, 8'h01);
		repeat (20) @(posedge clk_sys_in);
		wr(ADDR_DATA, 8'hFF);
		rd(ADDR_STATUS, 8'h40);
		chk(transfer_interrupt_out, 0);
		@(posedge clk_sys_in) stop_mode_in <= 1'b1;
		repeat (3) @(negedge clk_sys_in);
		held = {sck_out, serial_out_pin_out};
		repeat (40) @(negedge clk_sys_in);
		chk({sck_out, serial_out_pin_out}, held);
		@(posedge clk_sys_in) stop_mode_in <= 1'b0;
		wait_irq();
		chk(far_rx, 8'h80);
		rd(ADDR_STATUS, 8'hC0);
		rd(ADDR_DATA, 8'h69);
		rd(ADDR_STATUS, 8'h00);
	endtask : s_slow
	task automatic s_slave();
		wr(ADDR_CONTROL, 8'hC0);
		wr(ADDR_DATA, 8'h5C);
		repeat (10) @(negedge clk_sys_in);
		chk({sck_oe_out, sck_out}, 1);
		pulse_go(8'hE7);
		wait_irq();
		chk(far_rx, 8'h5C);
		wr(ADDR_DATA, 8'h11);
		rd(ADDR_STATUS, 8'h80);
		rd(ADDR_DATA, 8'hE7);
		@(posedge clk_sys_in) stop_mode_in <= 1'b1;
		pulse_go(8'h3C);
		wait_irq();
		rd(ADDR_STATUS, 8'h00);
		@(posedge clk_sys_in) stop_mode_in <= 1'b0;
		rd(ADDR_STATUS, 8'h80);
		rd(ADDR_DATA, 8'h3C);
		wr(ADDR_CONTROL, 8'h00);
		repeat (3) @(negedge clk_sys_in);
		chk({sck_oe_out, serial_out_oe_out}, 0);
	endtask : s_slave
	initial begin
		repeat (10) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		s_regs();
		s_master();
		s_slow();
		s_slave();
		report_and_stop();
	end
endmodule : serial_peripheral_port_tb
